/* File: hdl/rst_seq_pkg.sv */
// Package for the reset and stop-recovery sequencer: offsets, fields, timing and types
package rst_seq_pkg;
    // APB register byte offsets
    localparam logic [7:0] ctrl_offset   = 8'h00;
    localparam logic [7:0] status_offset = 8'h04;
    localparam logic [7:0] debug_offset  = 8'h08;
    localparam logic [7:0] option_offset = 8'h0c;
    // Control register fields
    localparam int ctrl_stop_bit   = 0;
    localparam int ctrl_pinout_bit = 1;
    // Status fields (cause bits in the upper nibble)
    localparam int stat_por_bit  = 7;
    localparam int stat_stop_bit = 6;
    localparam int stat_wdt_bit  = 5;
    localparam int stat_ext_bit  = 4;
    localparam int stat_busy_bit = 0;
    localparam int stat_stopd_bit = 1;
    localparam logic [7:0] status_reset = 8'h00;
    // Debugger control field
    localparam int debug_reset_bit = 0;
    // Option register fields and reset value
    localparam int opt_xtal_bit  = 0;
    localparam int opt_wdtrs_bit = 1;
    localparam int opt_boas_bit  = 2;
    localparam logic [2:0] option_reset = 3'h2;
    // Register reset values loaded on a system reset
    localparam logic [7:0] oscillator_control_reg_reset = 8'ha0;
    localparam logic [7:0] watchdog_control_register_reset = 8'h00;
    // Reset vector location
    localparam logic [15:0] vector_addr_hi = 16'h0002;
    localparam logic [15:0] vector_addr_lo = 16'h0003;
    // Timing
    localparam int clk_hz           = 20000000;
    localparam int osc_start_ns     = 4000;
    localparam int osc_start_cycles = (osc_start_ns * (clk_hz / 1000000) + 999) / 1000;
    localparam int hold_short       = 66;
    localparam int hold_long        = 5000;
    localparam int ext_min_cycles   = 3;
    // Reset sequencer states
    typedef enum logic [1:0] {st_run, st_start, st_hold, st_wait_pin} seq_state_t;
    // Reset cause carrier
    typedef struct packed {
        logic por;
        logic stop;
        logic wdt;
        logic ext;
    } cause_t;
endpackage

/* File: hdl/reset_stop_recovery_sequencer.sv */
// Reset and stop-recovery sequencer with APB register access
// Summary of operation
// - Hold CPU in reset 66 oscillator cycles after start-up, crystal off.
// - With crystal option set, hold period becomes 5000 cycles.
// - Allow oscillator start-up interval before the hold count begins.
// - Power-on or brown-out delay counts only once supply exceeds power-on level.
// - Stay in reset while external reset pin stays asserted after count.
// - At reset start, general pins become inputs with pull-ups off.
// - Shared reset pin is open-drain, driven low during system reset until the hold count ends.
// - CPU and peripherals idle in reset; oscillators keep running.
// - Load control registers with their reset values on reset.
// - CPU fetches vector from 0002H and 0003H on leaving reset.
// - System reset selects the internal oscillator as system clock.
// - Stop recovery resets CPU, touching only watchdog and oscillator control.
// - External reset pulses under three clocks are ignored in run mode.
// - Debugger control bit 0 set causes system reset, debugger unaffected.
// - In stop mode, external pulses are qualified by analog filter instead.
// - Remain in reset until power-on counter expires after supply rises.
// - Set power-on flag in status after power-on reset.
// - Brown-out enters reset, holds while supply low, then full reset.
// - Option bit decides if brown-out works during stop mode.
// - Watchdog timeout resets when action option is 1, else interrupts.
// - Watchdog-caused reset sets the watchdog cause flag.
// - Four-cycle external reset always resets; three may.
// - Reading status clears its upper four cause bits.
`timescale 1ns/10ps
module reset_stop_recovery_sequencer #(
    parameter int unsigned long_hold = rst_seq_pkg::hold_long
) (
    // Clock, reset, enable
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Analog supply monitors and filtered stop-mode pin
    input  wire logic        supply_above_por,
    input  wire logic        brownout_detect,
    input  wire logic        stop_pin_filtered_n,
    // Event sources
    input  wire logic        watchdog_timeout,
    input  wire logic        stop_recovery_req,
    input  wire logic        debug_pin_low,
    // Shared reset pin, open-drain
    input  wire logic        shared_reset_pin_in,
    output logic             shared_reset_pin_out,
    output logic             shared_reset_pin_oe_n,
    // System outputs
    output logic             cpu_reset,
    output logic             periph_idle,
    output logic             ctrl_regs_load,
    output logic             wdt_osc_regs_load,
    output logic             gpio_inputs_no_pullup,
    output logic             sysclk_select_ipo,
    output logic [15:0]      vector_fetch_addr,
    output logic             vector_fetch,
    output logic             watchdog_irq,
    output logic             debugger_reset_keep
);
    initial begin
        if (long_hold < 2 || long_hold > 65535) $error("long_hold out of range");
    end

    rst_seq_pkg::seq_state_t state;
    rst_seq_pkg::cause_t     cause;
    logic [15:0] hold_cnt;
    logic [2:0]  pin_sync;
    logic [1:0]  pin_low_run;
    logic        pin_low;
    logic        ext_req;
    logic        stop_mode;
    logic        pin_gpio_out;
    logic [2:0]  option_bits;
    logic        debugger_control_reg;
    logic        vec_phase;
    logic        supply_ok_seen;
    logic        wdt_reset_req;
    logic        bo_active;
    logic        sys_req;
    logic        smr_req;
    logic        any_req;
    logic        is_xtal;
    logic [15:0] hold_target;
    logic        apb_write;
    logic        apb_read;
    logic        status_read;
    logic        pin_driven;
    logic [2:0]  drive_hist;
    logic        pin_masked;
    logic        pin_low_ext;

    // Three-stage synchroniser; second and third stage agreement qualifies
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_sync <= 3'h7;
        end else if (clk_en) begin
            pin_sync <= {pin_sync[1:0], shared_reset_pin_in};
        end
    end
    assign pin_low = ~pin_sync[2] & ~pin_sync[1];

    // Own-drive history: the synchroniser still shows our own low for three clocks
    // after we let go, so an outside request is only believed once that has drained.
    // Limitation: a board press while we pull the pin cannot be told apart from our own drive.
    always_ff @(posedge mclk) begin
        if (rst) begin
            drive_hist <= 3'h7;
        end else if (clk_en) begin
            drive_hist <= {drive_hist[1:0], pin_driven};
        end
    end
    assign pin_masked  = pin_driven | pin_gpio_out | (|drive_hist);
    assign pin_low_ext = pin_low & ~pin_masked;

    // Run-mode qualification: low must persist three clocks
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_low_run <= 2'h0;
        end else if (clk_en) begin
            if (!pin_low_ext) begin
                pin_low_run <= 2'h0;
            end else if (pin_low_run != 2'h3) begin
                pin_low_run <= pin_low_run + 2'h1;
            end
        end
    end

    // Stop mode uses the analog-filtered pin instead of the clock count
    assign ext_req = stop_mode ? ~stop_pin_filtered_n : (pin_low_run == 2'h2 || pin_low_run == 2'h3);

    // Brown-out only counts in stop mode when its option allows it
    assign bo_active     = brownout_detect & (~stop_mode | option_bits[rst_seq_pkg::opt_boas_bit]);
    assign wdt_reset_req = watchdog_timeout & option_bits[rst_seq_pkg::opt_wdtrs_bit] & ~stop_mode;
    assign sys_req       = ext_req | wdt_reset_req | debugger_control_reg | bo_active | ~supply_above_por
                         | (stop_mode & debug_pin_low);
    assign smr_req       = stop_mode & (stop_recovery_req | watchdog_timeout);
    assign any_req       = sys_req | smr_req;
    assign is_xtal       = option_bits[rst_seq_pkg::opt_xtal_bit];
    assign hold_target   = is_xtal ? long_hold[15:0] : 16'(rst_seq_pkg::hold_short);

    // Interrupt instead of reset when the action option is clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            watchdog_irq <= 1'b0;
        end else if (clk_en) begin
            watchdog_irq <= watchdog_timeout & ~option_bits[rst_seq_pkg::opt_wdtrs_bit];
        end
    end

    // Sequencer: start-up, counted hold, pin wait
    always_ff @(posedge mclk) begin
        if (rst) begin
            state    <= rst_seq_pkg::st_start;
            hold_cnt <= 16'h0000;
        end else if (clk_en) begin
            if (~supply_above_por | bo_active) begin
                state    <= rst_seq_pkg::st_start;
                hold_cnt <= 16'h0000;
            end else if (any_req && state != rst_seq_pkg::st_wait_pin) begin
                state    <= rst_seq_pkg::st_start;
                hold_cnt <= 16'h0000;
            end else begin
                case (state)
                    rst_seq_pkg::st_run: begin
                        hold_cnt <= 16'h0000;
                    end
                    rst_seq_pkg::st_start: begin
                        if (hold_cnt == 16'(rst_seq_pkg::osc_start_cycles - 1)) begin
                            state    <= rst_seq_pkg::st_hold;
                            hold_cnt <= 16'h0000;
                        end else begin
                            hold_cnt <= hold_cnt + 16'h0001;
                        end
                    end
                    rst_seq_pkg::st_hold: begin
                        if (hold_cnt == hold_target - 16'h0001) begin
                            // Always pass the pin wait so the released pin can settle first
                            state    <= rst_seq_pkg::st_wait_pin;
                            hold_cnt <= 16'h0000;
                        end else begin
                            hold_cnt <= hold_cnt + 16'h0001;
                        end
                    end
                    rst_seq_pkg::st_wait_pin: begin
                        if ((!pin_low || pin_gpio_out) && drive_hist == 3'h0) begin
                            state <= rst_seq_pkg::st_run;
                        end
                    end
                    default: begin
                        state <= rst_seq_pkg::st_start;
                    end
                endcase
            end
        end
    end

    // Stop mode flag: set by software, cleared by any recovery
    always_ff @(posedge mclk) begin
        if (rst) begin
            stop_mode <= 1'b0;
        end else if (clk_en) begin
            if (state != rst_seq_pkg::st_run) begin
                stop_mode <= 1'b0;
            end else if (apb_write && paddr == rst_seq_pkg::ctrl_offset) begin
                stop_mode <= pwdata[rst_seq_pkg::ctrl_stop_bit];
            end
        end
    end

    // Distinguish full reset from stop recovery for the register loads
    always_ff @(posedge mclk) begin
        if (rst) begin
            supply_ok_seen <= 1'b1;
        end else if (clk_en) begin
            if (sys_req) begin
                supply_ok_seen <= 1'b1;
            end else if (state == rst_seq_pkg::st_run) begin
                supply_ok_seen <= 1'b0;
            end
        end
    end

    // Reset-side outputs
    assign cpu_reset             = (state != rst_seq_pkg::st_run);
    assign periph_idle           = cpu_reset & supply_ok_seen;
    assign ctrl_regs_load        = cpu_reset & supply_ok_seen;
    assign wdt_osc_regs_load     = cpu_reset;
    assign gpio_inputs_no_pullup = cpu_reset & supply_ok_seen;
    assign sysclk_select_ipo     = cpu_reset;
    assign debugger_reset_keep   = 1'b1;
    // Open-drain pin: enable low pulls the wire low
    assign shared_reset_pin_out  = 1'b0;
    // Drive stops at the end of the count; the pin wait then listens to the board alone
    assign pin_driven            = cpu_reset & supply_ok_seen & (state != rst_seq_pkg::st_wait_pin);
    assign shared_reset_pin_oe_n = ~(pin_driven | pin_gpio_out);

    // Vector fetch: two reads after reset release
    always_ff @(posedge mclk) begin
        if (rst) begin
            vec_phase         <= 1'b0;
            vector_fetch      <= 1'b0;
            vector_fetch_addr <= rst_seq_pkg::vector_addr_hi;
        end else if (clk_en) begin
            vector_fetch <= 1'b0;
            if (cpu_reset) begin
                vec_phase <= 1'b1;
            end else if (vec_phase) begin
                vector_fetch      <= 1'b1;
                vector_fetch_addr <= vector_fetch ? rst_seq_pkg::vector_addr_lo : rst_seq_pkg::vector_addr_hi;
                vec_phase         <= ~vector_fetch;
            end
        end
    end

    // APB decode: zero wait states
    assign pready      = 1'b1;
    assign pslverr     = 1'b0;
    assign apb_write   = psel & penable & pwrite;
    assign apb_read    = psel & penable & ~pwrite;
    assign status_read = apb_read & (paddr == rst_seq_pkg::status_offset);

    // Debug reset bit, self-clearing during system reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            debugger_control_reg <= 1'b0;
        end else if (clk_en) begin
            if (apb_write && paddr == rst_seq_pkg::debug_offset) begin
                debugger_control_reg <= pwdata[rst_seq_pkg::debug_reset_bit];
            end else if (state == rst_seq_pkg::st_start) begin
                debugger_control_reg <= 1'b0;
            end
        end
    end

    // Options and pin mode; pin returns to reset duty on every system reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            option_bits  <= rst_seq_pkg::option_reset;
            pin_gpio_out <= 1'b0;
        end else if (clk_en) begin
            if (ctrl_regs_load) begin
                pin_gpio_out <= 1'b0;
            end else if (apb_write && paddr == rst_seq_pkg::ctrl_offset) begin
                pin_gpio_out <= pwdata[rst_seq_pkg::ctrl_pinout_bit];
            end
            if (apb_write && paddr == rst_seq_pkg::option_offset) begin
                option_bits <= pwdata[2:0];
            end
        end
    end

    // Cause flags: hardware set wins over read clear; recorded when reset is entered
    always_ff @(posedge mclk) begin
        if (rst) begin
            cause <= '{por: 1'b1, default: 1'b0};
        end else if (clk_en) begin
            if (status_read) begin
                cause <= '0;
            end
            if (state == rst_seq_pkg::st_run && any_req) begin
                cause.por  <= ~supply_above_por | bo_active | debugger_control_reg;
                cause.stop <= smr_req;
                cause.wdt  <= watchdog_timeout;
                cause.ext  <= ext_req;
            end
        end
    end

    // Read data register
    always_ff @(posedge mclk) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (clk_en) begin
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    rst_seq_pkg::ctrl_offset:   prdata <= {30'h0, pin_gpio_out, stop_mode};
                    rst_seq_pkg::status_offset: prdata <= {24'h0, cause, 2'h0, stop_mode, cpu_reset};
                    rst_seq_pkg::debug_offset:  prdata <= {31'h0, debugger_control_reg};
                    rst_seq_pkg::option_offset: prdata <= {29'h0, option_bits};
                    default:                    prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Checks
    property p_hold_count;
        @(posedge mclk) disable iff (rst)
            ($rose(state == rst_seq_pkg::st_hold) && !is_xtal && clk_en) |-> (cpu_reset throughout ##[1:65] 1'b1);
    endproperty
    a_hold_count: assert property (p_hold_count) else $error("short hold ended early");
    property p_short_hold;
        @(posedge mclk) disable iff (rst) $rose(cpu_reset) |-> cpu_reset [*8];
    endproperty
    a_short_hold: assert property (p_short_hold) else $error("hold too short");
    property p_ext_wait;
        @(posedge mclk) disable iff (rst) (state == rst_seq_pkg::st_wait_pin && pin_low) |=> cpu_reset;
    endproperty
    a_ext_wait: assert property (p_ext_wait) else $error("left reset with pin low");
    property p_supply;
        @(posedge mclk) disable iff (rst) (!supply_above_por && clk_en) |=> state == rst_seq_pkg::st_start;
    endproperty
    a_supply: assert property (p_supply) else $error("count ran below por");
    property p_pin_drive;
        @(posedge mclk) disable iff (rst)
            (cpu_reset && supply_ok_seen && state != rst_seq_pkg::st_wait_pin) |-> !shared_reset_pin_oe_n;
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("pin not driven in reset");
    property p_stat_clear;
        @(posedge mclk) disable iff (rst) (status_read && clk_en && state == rst_seq_pkg::st_run) |=> cause == '0;
    endproperty
    a_stat_clear: assert property (p_stat_clear) else $error("cause not cleared");
    property p_glitch;
        @(posedge mclk) disable iff (rst) (!stop_mode && pin_low_run < 2'h2) |-> !ext_req;
    endproperty
    a_glitch: assert property (p_glitch) else $error("short pulse accepted");
    property p_vector;
        @(posedge mclk) disable iff (rst) $rose(vector_fetch) |-> vector_fetch_addr == rst_seq_pkg::vector_addr_hi;
    endproperty
    a_vector: assert property (p_vector) else $error("wrong vector address");
    property p_ipo;
        @(posedge mclk) disable iff (rst) cpu_reset |-> sysclk_select_ipo;
    endproperty
    a_ipo: assert property (p_ipo) else $error("ipo not selected");
    c_wait_pin: cover property (@(posedge mclk) state == rst_seq_pkg::st_wait_pin);
    c_release:  cover property (@(posedge mclk) $fell(cpu_reset));
    c_smr:      cover property (@(posedge mclk) stop_mode ##1 cpu_reset);
endmodule // reset_stop_recovery_sequencer

/* File: bench/board_reset_model.sv */
// Board side of the shared reset pin and debug pin: pull-up, push button, debugger
`timescale 1ns/10ps
module board_reset_model (
    // Clock
    input  wire logic mclk,
    // Device side of the open-drain pin
    input  wire logic pin_out,
    input  wire logic pin_oe_n,
    // Resolved levels
    output logic      pin_level,
    output logic      debug_low
);
    logic board_low;

    initial begin
        board_low = 1'b0;
        debug_low = 1'b0;
    end

    // Wired-and with pull-up: any party pulling low wins, released line floats high
    assign pin_level = (board_low || (!pin_oe_n && !pin_out)) ? 1'b0 : 1'b1;

    // Button held low for n clocks; changes land just after an edge
    task automatic press(input int n);
        board_low <= 1'b1;
        repeat (n) @(posedge mclk);
        board_low <= 1'b0;
    endtask

    // Debugger pulls its pin low for n clocks
    task automatic debug_press(input int n);
        debug_low <= 1'b1;
        repeat (n) @(posedge mclk);
        debug_low <= 1'b0;
    endtask
endmodule // board_reset_model

/* File: bench/tb.sv */
// Self-checking testbench for the reset and stop-recovery sequencer
`timescale 1ns/10ps
module tb;
    localparam int hold = 20;
    localparam int st   = rst_seq_pkg::osc_start_cycles;
    logic        mclk, rst, clk_en, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        supply_ok, brownout, stop_pin_n, wdt_to, stop_req, pin_lvl, pin_out, pin_oe_n, dbg_low;
    logic        cpu_reset, periph_idle, ctrl_load, wo_load, gpio_in, sys_ipo, vfetch, wdt_irq, dbg_keep;
    logic [15:0] vaddr;
    int          bad_count, checks_done, n;

    board_reset_model board (.mclk(mclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_level(pin_lvl),
                             .debug_low(dbg_low));

    reset_stop_recovery_sequencer #(.long_hold(hold)) dut (
        .mclk(mclk), .rst(rst), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .supply_above_por(supply_ok), .brownout_detect(brownout), .stop_pin_filtered_n(stop_pin_n),
        .watchdog_timeout(wdt_to), .stop_recovery_req(stop_req), .debug_pin_low(dbg_low),
        .shared_reset_pin_in(pin_lvl), .shared_reset_pin_out(pin_out), .shared_reset_pin_oe_n(pin_oe_n),
        .cpu_reset(cpu_reset), .periph_idle(periph_idle), .ctrl_regs_load(ctrl_load),
        .wdt_osc_regs_load(wo_load), .gpio_inputs_no_pullup(gpio_in), .sysclk_select_ipo(sys_ipo),
        .vector_fetch_addr(vaddr), .vector_fetch(vfetch), .watchdog_irq(wdt_irq),
        .debugger_reset_keep(dbg_keep));

    // Clock at 20 MHz
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // One APB transfer; request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge mclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        @(posedge mclk);
        while (pready !== 1'b1 && k < 50) begin
            @(posedge mclk);
            k++;
        end
        rd = prdata;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // Cycles until the CPU leaves reset, bounded; also watches the vector fetch order
    task automatic wait_run(output int len);
        int fetches;
        len = 0;
        fetches = 0;
        while (cpu_reset !== 1'b0 && len < 6000) begin
            @(posedge mclk);
            len++;
        end
        repeat (6) begin
            #1;
            if (vfetch === 1'b1) begin
                check("vector address", vaddr, fetches == 0 ? 16'h0002 : 16'h0003);
                fetches++;
            end
            @(posedge mclk);
        end
        check("vector fetch count", fetches, 2);
    endtask

    // Bounded wait for reset entry after a request
    task automatic wait_entry();
        n = 0;
        while (cpu_reset !== 1'b1 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        #1;
        check("reset entered", cpu_reset, 1'b1);
    endtask

    function automatic logic near(input int got, input int exp);
        return got + 2 >= exp && got <= exp + 8;
    endfunction

    // Power-on: start-up plus short hold, pin pulled, pins and clock defaults, status
    task automatic t_power_on();
        #1;
        check("ipo during reset", sys_ipo, 1'b1);
        check("gpio inputs", gpio_in, 1'b1);
        check("pin pulled", pin_oe_n, 1'b0);
        check("periph idle", periph_idle, 1'b1);
        check("ctrl load", ctrl_load, 1'b1);
        wait_run(n);
        check("power-on length", near(n, st + 66), 1'b1);
        apb(1'b0, rst_seq_pkg::status_offset, 32'h0);
        check("por flag", rd[7:4], 4'h8);
        apb(1'b0, rst_seq_pkg::status_offset, 32'h0);
        check("cause cleared", rd[7:4], 4'h0);
        apb(1'b0, rst_seq_pkg::option_offset, 32'h0);
        check("option reset", rd[2:0], 3'h2);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped read", rd, 32'h0);
        $display("test power_on done");
    endtask

    // Debugger reset with crystal option: long hold, debugger kept
    task automatic t_debug_crystal();
        apb(1'b1, rst_seq_pkg::option_offset, 32'h3);
        apb(1'b1, rst_seq_pkg::debug_offset, 32'h1);
        wait_entry();
        check("debugger kept", dbg_keep, 1'b1);
        wait_run(n);
        check("crystal length", near(n + 1, st + hold), 1'b1);
        apb(1'b1, rst_seq_pkg::option_offset, 32'h2);
        $display("test debug_crystal done");
    endtask

    // Reset pin: short pulse ignored, four clocks taken, restart, held pin
    task automatic t_ext_pin();
        board.press(2);
        repeat (20) @(posedge mclk);
        check("short pulse", cpu_reset, 1'b0);
        board.press(4);
        wait_entry();
        repeat (60) @(posedge mclk);
        wdt_to <= 1'b1;
        @(posedge mclk);
        wdt_to <= 1'b0;
        wait_run(n);
        check("restarted hold", n > st + 66, 1'b1);
        apb(1'b0, rst_seq_pkg::status_offset, 32'h0);
        check("ext flag", rd[7:4], 4'h1);
        fork
            board.press(300);
            wait_entry();
        join
        #1;
        check("held by pin", cpu_reset, 1'b1);
        wait_run(n);
        check("exit after release", n < 12, 1'b1);
        $display("test ext_pin done");
    endtask

    // Watchdog: reset when action bit set, interrupt otherwise
    task automatic t_watchdog();
        wdt_to <= 1'b1;
        @(posedge mclk);
        wdt_to <= 1'b0;
        wait_entry();
        wait_run(n);
        apb(1'b0, rst_seq_pkg::status_offset, 32'h0);
        check("wdt flag", rd[7:4], 4'h2);
        apb(1'b1, rst_seq_pkg::option_offset, 32'h0);
        wdt_to <= 1'b1;
        @(posedge mclk);
        wdt_to <= 1'b0;
        n = 0;
        repeat (4) begin
            #1;
            n = n | (wdt_irq === 1'b1 ? 1 : 0) | (cpu_reset === 1'b1 ? 2 : 0);
            @(posedge mclk);
        end
        check("wdt irq only", n, 1);
        apb(1'b1, rst_seq_pkg::option_offset, 32'h2);
        $display("test watchdog done");
    endtask

    // Stop recovery keeps control registers; filtered pin in stop gives system reset
    task automatic t_stop();
        apb(1'b1, rst_seq_pkg::ctrl_offset, 32'h1);
        stop_req <= 1'b1;
        repeat (2) @(posedge mclk);
        stop_req <= 1'b0;
        wait_entry();
        check("stop keeps regs", {periph_idle, ctrl_load, wo_load, sys_ipo}, 4'h3);
        wait_run(n);
        check("stop length", near(n + 1, st + 66), 1'b1);
        apb(1'b0, rst_seq_pkg::status_offset, 32'h0);
        check("stop flag", rd[7:4], 4'h4);
        apb(1'b1, rst_seq_pkg::ctrl_offset, 32'h1);
        stop_pin_n <= 1'b0;
        repeat (2) @(posedge mclk);
        stop_pin_n <= 1'b1;
        wait_entry();
        check("stop pin system reset", periph_idle, 1'b1);
        wait_run(n);
        $display("test stop done");
    endtask

    // Brown-out: held while supply low, counted from supply rise
    task automatic t_brownout();
        brownout <= 1'b1;
        supply_ok <= 1'b0;
        wait_entry();
        repeat (300) @(posedge mclk);
        check("held while low", cpu_reset, 1'b1);
        brownout <= 1'b0;
        supply_ok <= 1'b1;
        @(posedge mclk);
        wait_run(n);
        check("count from supply", near(n + 1, st + 66), 1'b1);
        $display("test brownout done");
    endtask

    // Hang guard, well beyond the expected two thousand or so cycles
    initial begin
        repeat (40000) @(posedge mclk);
        bad_count++;
        end_of_test();
    end

    initial begin
        bad_count = 0; checks_done = 0;
        rst = 1'b1; clk_en = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; supply_ok = 1'b1; brownout = 1'b0;
        stop_pin_n = 1'b1; wdt_to = 1'b0; stop_req = 1'b0;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        t_power_on();
        t_debug_crystal();
        t_ext_pin();
        t_watchdog();
        t_stop();
        t_brownout();
        end_of_test();
    end
endmodule // tb
